// ---- bdsp_port.sv ----
// Serial control port and register file of the bridge driver
`timescale 1ns/1ps
`default_nettype none
module bdsp_port (
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   input  wire logic        sck_i,
   input  wire logic        sdi_i,
   input  wire logic        select_strobe_n_i,
   output logic             sdo_o,
   output logic             sdo_oe_o,
   input  wire logic [9:0]  fault_a_set_i,
   input  wire logic [9:0]  fault_b_set_i,
   input  wire logic [9:0]  fault_c_set_i,
   input  wire logic [9:0]  verify_a_set_i,
   input  wire logic [9:0]  verify_b_set_i,
   input  wire logic [3:0]  monitor_live_i,
   input  wire logic        commit_ready_i,
   output logic             commit_valid_o,
   output logic [3:0]       commit_addr_o,
   output logic [9:0]       bridge_timing_cfg_o,
   output logic [9:0]       monitor_cfg_a_o,
   output logic [9:0]       monitor_cfg_b_o,
   output logic [9:0]       monitor_cfg_c_o,
   output logic [9:0]       monitor_cfg_d_o,
   output logic [9:0]       sense_amp_cfg_o,
   output logic [9:0]       verify_command_a_o,
   output logic [9:0]       verify_command_b_o,
   output logic [9:0]       monitor_disable_a_o,
   output logic [9:0]       monitor_disable_b_o,
   output logic [9:0]       bridge_control_o,
   output logic [14:0]      summary_status_o
);
   typedef enum logic [0:0] {
      ST_IDLE  = 1'b0,
      ST_FRAME = 1'b1
   } bdsp_state_t;

   // Pin synchronisers; bit 0 is the first stage
   logic [1:0]   sck_sync_q;
   logic [1:0]   sdi_sync_q;
   logic [1:0]   stb_sync_q;
   logic         sck_prev_q;
   logic         stb_prev_q;
   wire logic    sck_s;
   wire logic    sdi_s;
   wire logic    stb_s;

   bdsp_state_t  state_q;
   bdsp_state_t  state_d;
   logic [4:0]   cnt_q;
   logic [15:0]  shift_q;
   logic [15:0]  resp_q;
   logic [4:0]   head_q;
   logic         sdo_q;
   logic         oe_q;

   logic [9:0]   regs_q [bdsp_pkg::NREG];
   logic [9:0]   regs_d [bdsp_pkg::NREG];
   logic [3:0]   lat_q;
   logic         por_q;
   logic         serr_q;
   logic [14:0]  stat_q;
   logic         cval_q;
   logic [3:0]   caddr_q;

   // Edge and frame decode
   wire logic    sck_rise;
   wire logic    sck_fall;
   wire logic    stb_fall;
   wire logic    stb_rise;
   wire logic    in_frame;
   wire logic    rise_ev;
   wire logic    fall_ev;
   wire logic    head_fill;
   wire logic    end_ev;
   wire logic    good_frame;
   wire logic    push_valid;
   wire logic    serr_set;
   wire logic [4:0]  cnt_d;
   wire logic [3:0]  h_addr;
   wire logic        h_wr;
   wire logic [9:0]  low10;
   wire logic        par;

   // Commit decode
   wire logic        buf_in_ready;
   wire logic        buf_out_valid;
   wire logic [15:0] buf_word;
   wire logic        pop;
   wire logic [3:0]  c_addr;
   wire logic        c_wr;
   wire logic [9:0]  c_data;
   wire logic        c_ro;
   wire logic        wr_reg;
   wire logic        stat_clr;
   wire logic        rd_clr;

   // Monitor gating and status
   wire logic [9:0]  m_a;
   wire logic [9:0]  m_b;
   wire logic [9:0]  set_a;
   wire logic [9:0]  set_b;
   wire logic [9:0]  set_c;
   wire logic [3:0]  live_m;
   wire logic [3:0]  lat_d;
   wire logic [13:0] stat_rest;
   wire logic [14:0] stat_d;

   assign sck_s    = sck_sync_q[1];
   assign sdi_s    = sdi_sync_q[1];
   assign stb_s    = stb_sync_q[1];
   assign sck_rise = sck_s & ~sck_prev_q;
   assign sck_fall = ~sck_s & sck_prev_q;
   assign stb_fall = ~stb_s & stb_prev_q;
   assign stb_rise = stb_s & ~stb_prev_q;
   assign in_frame = state_q == ST_FRAME;
   // Clock edges only count inside a frame with the strobe low
   assign rise_ev  = sck_rise & in_frame & ~stb_s;
   assign fall_ev  = sck_fall & in_frame & ~stb_s;
   assign cnt_d    = (cnt_q == bdsp_pkg::CNT_OVER) ? cnt_q
                   : cnt_q + 5'h01;
   assign head_fill = rise_ev & (cnt_q == bdsp_pkg::CNT_HEAD);
   // Address is complete once the write bit arrives
   assign h_addr   = shift_q[3:0];
   assign h_wr     = sdi_s;
   // Writes answer with status, reads with the register
   assign low10    = h_wr ? stat_q[9:0] : regs_q[h_addr];
   assign par      = bdsp_pkg::odd_parity({head_q, low10});
   assign end_ev   = stb_rise & in_frame;
   assign good_frame = cnt_q == bdsp_pkg::CNT_FULL;
   assign push_valid = end_ev & good_frame;
   // A full buffer refuses the word like a broken frame
   assign serr_set = end_ev & (~good_frame | ~buf_in_ready);

   always_comb begin
      case (state_q)
         ST_IDLE:  state_d = stb_fall ? ST_FRAME : ST_IDLE;
         ST_FRAME: state_d = stb_rise ? ST_IDLE : ST_FRAME;
         default:  state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         // Serial clock idles low, so no false edge follows reset
         sck_sync_q <= 2'h0;
         sdi_sync_q <= 2'h0;
         stb_sync_q <= 2'h3;
         sck_prev_q <= 1'b0;
         stb_prev_q <= 1'b1;
      end else begin
         sck_sync_q <= {sck_sync_q[0], sck_i};
         sdi_sync_q <= {sdi_sync_q[0], sdi_i};
         stb_sync_q <= {stb_sync_q[0], select_strobe_n_i};
         sck_prev_q <= sck_s;
         stb_prev_q <= stb_s;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         state_q <= ST_IDLE;
         cnt_q   <= 5'h00;
         shift_q <= 16'h0000;
      end else begin
         state_q <= state_d;
         if (stb_fall) begin
            cnt_q <= 5'h00;
         end else if (rise_ev) begin
            cnt_q   <= cnt_d;
            shift_q <= {shift_q[14:0], sdi_s};
         end
      end
   end

   // Response path: head from status at strobe fall, tail after bit 11
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         resp_q <= 16'h0000;
         head_q <= 5'h00;
         sdo_q  <= 1'b0;
         oe_q   <= 1'b0;
      end else if (stb_fall) begin
         resp_q <= {stat_q[14:10], 11'h000};
         head_q <= stat_q[14:10];
         sdo_q  <= stat_q[14];
         oe_q   <= 1'b1;
      end else if (stb_rise) begin
         sdo_q  <= 1'b0;
         oe_q   <= 1'b0;
      end else if (head_fill) begin
         resp_q <= {resp_q[15], low10, par, 4'h0};
      end else if (fall_ev) begin
         resp_q <= {resp_q[14:0], 1'b0};
         sdo_q  <= resp_q[14];
      end
   end

   bdsp_buf #(
      .WIDTH (bdsp_pkg::FRAME_W),
      .DEPTH (2)
   ) u_buf (
      .clk_i       (clk_i),
      .reset_i     (reset_i),
      .in_valid_i  (push_valid),
      .in_ready_o  (buf_in_ready),
      .in_data_i   (shift_q),
      .out_valid_o (buf_out_valid),
      .out_ready_i (commit_ready_i),
      .out_data_o  (buf_word)
   );

   assign pop      = buf_out_valid & commit_ready_i;
   assign c_addr   = buf_word[15:12];
   assign c_wr     = buf_word[11];
   assign c_data   = buf_word[10:1];
   assign c_ro     = bdsp_pkg::is_read_only(c_addr);
   assign wr_reg   = pop & c_wr & ~c_ro;
   assign stat_clr = pop & c_wr;
   assign rd_clr   = pop & ~c_wr & c_ro;

   assign m_a    = regs_q[bdsp_pkg::A_MASK_A];
   assign m_b    = regs_q[bdsp_pkg::A_MASK_B];
   assign set_a  = fault_a_set_i & ~m_a;
   assign set_b  = fault_b_set_i & ~m_b;
   assign set_c  = fault_c_set_i & ~{m_b[bdsp_pkg::M_B_VBB],
                   m_b[bdsp_pkg::M_B_VBB], 1'b0,
                   m_a[bdsp_pkg::M_A_BOOT],
                   m_a[bdsp_pkg::M_A_BOOT], 5'h00};
   assign live_m = monitor_live_i & ~{1'b0, m_a[bdsp_pkg::M_A_TWARN],
                   m_b[bdsp_pkg::M_B_LOGIC], 1'b0};

   // Sticky sets win over the clear of the same cycle
   always_comb begin
      for (int i = 0; i < bdsp_pkg::NREG; i++) begin
         if (wr_reg && c_addr == 4'(i)) begin
            regs_d[i] = c_data;
         end else if (rd_clr && c_addr == 4'(i)) begin
            regs_d[i] = 10'h000;
         end else begin
            regs_d[i] = regs_q[i];
         end
      end
      regs_d[bdsp_pkg::A_VRES_A] = regs_d[bdsp_pkg::A_VRES_A]
                                 | verify_a_set_i;
      regs_d[bdsp_pkg::A_VRES_B] = regs_d[bdsp_pkg::A_VRES_B]
                                 | verify_b_set_i;
      regs_d[bdsp_pkg::A_DIAG_A] = regs_d[bdsp_pkg::A_DIAG_A] | set_a;
      regs_d[bdsp_pkg::A_DIAG_B] = regs_d[bdsp_pkg::A_DIAG_B] | set_b;
      regs_d[bdsp_pkg::A_DIAG_C] = regs_d[bdsp_pkg::A_DIAG_C] | set_c;
   end

   // Latched monitors drop on a status clear only when no longer live
   assign lat_d = (lat_q & ~{4{stat_clr}}) | live_m;
   assign stat_rest = {por_q, serr_q, 1'b0, lat_q[3], lat_q[2],
      |regs_q[bdsp_pkg::A_DIAG_C][9:8], lat_q[1], lat_q[0],
      |regs_q[bdsp_pkg::A_DIAG_B][9:8],
      |regs_q[bdsp_pkg::A_DIAG_A][9:8],
      |regs_q[bdsp_pkg::A_DIAG_C][2:0],
      |regs_q[bdsp_pkg::A_DIAG_C][6:5],
      |regs_q[bdsp_pkg::A_DIAG_A][3:0],
      |regs_q[bdsp_pkg::A_DIAG_B][3:0]};
   assign stat_d = {|stat_rest, stat_rest};

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         for (int i = 0; i < bdsp_pkg::NREG; i++) begin
            regs_q[i] <= bdsp_pkg::reg_reset(4'(i));
         end
      end else begin
         for (int i = 0; i < bdsp_pkg::NREG; i++) begin
            regs_q[i] <= regs_d[i];
         end
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         lat_q   <= 4'h0;
         por_q   <= 1'b1;
         serr_q  <= 1'b0;
         stat_q  <= 15'h6000;
         cval_q  <= 1'b0;
         caddr_q <= 4'h0;
      end else begin
         lat_q   <= lat_d;
         por_q   <= por_q & ~stat_clr;
         serr_q  <= (serr_q & ~stat_clr) | serr_set;
         stat_q  <= stat_d;
         cval_q  <= pop;
         caddr_q <= pop ? c_addr : caddr_q;
      end
   end

   assign sdo_o               = sdo_q;
   assign sdo_oe_o            = oe_q;
   assign commit_valid_o      = cval_q;
   assign commit_addr_o       = caddr_q;
   assign bridge_timing_cfg_o = regs_q[bdsp_pkg::A_TIMING];
   assign monitor_cfg_a_o     = regs_q[bdsp_pkg::A_MON_A];
   assign monitor_cfg_b_o     = regs_q[bdsp_pkg::A_MON_B];
   assign monitor_cfg_c_o     = regs_q[bdsp_pkg::A_MON_C];
   assign monitor_cfg_d_o     = regs_q[bdsp_pkg::A_MON_D];
   assign sense_amp_cfg_o     = regs_q[bdsp_pkg::A_SENSE];
   assign verify_command_a_o  = regs_q[bdsp_pkg::A_VCMD_A];
   assign verify_command_b_o  = regs_q[bdsp_pkg::A_VCMD_B];
   assign monitor_disable_a_o = regs_q[bdsp_pkg::A_MASK_A];
   assign monitor_disable_b_o = regs_q[bdsp_pkg::A_MASK_B];
   assign bridge_control_o    = regs_q[bdsp_pkg::A_CTRL];
   assign summary_status_o    = stat_q;

   // Checks
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);

   sequence s_good_end;
      end_ev && good_frame && buf_in_ready;
   endsequence

   sequence s_bad_end;
      end_ev && !good_frame;
   endsequence

   sequence s_frame_open;
      stb_fall ##1 oe_q;
   endsequence

   a_idle_no_shift: assert property (
      !in_frame && !stb_fall |=> $stable(shift_q) && $stable(cnt_q))
      else $error("shift register moved outside a frame");

   a_idle_released: assert property (
      (state_q == ST_IDLE) && !stb_fall |=> !oe_q)
      else $error("serial output driven while strobe high");

   a_first_bit_ff: assert property (
      stb_fall |=> sdo_q == $past(stat_q[14]) && oe_q)
      else $error("first output bit is not the fault flag");

   a_frame_commit: assert property (
      s_good_end |=> buf_out_valid)
      else $error("good frame not queued for commit");

   a_bad_frame_err: assert property (
      s_bad_end |-> !push_valid ##1 serr_q)
      else $error("broken frame did not raise serial error");

   a_err_sticky: assert property (
      serr_q && !stat_clr |=> serr_q)
      else $error("serial error dropped without valid write");

   a_err_cleared: assert property (
      stat_clr && !serr_set |=> !serr_q)
      else $error("serial error kept after valid write");

   a_write_stores: assert property (
      wr_reg |=> regs_q[$past(c_addr)] == $past(c_data))
      else $error("written data not stored");

   a_read_keeps: assert property (
      pop && !c_wr && !c_ro
      |=> regs_q[$past(c_addr)] == $past(regs_q[c_addr]))
      else $error("read changed a register");

   a_ro_write_kept: assert property (
      stat_clr && c_ro && c_addr == bdsp_pkg::A_DIAG_A && set_a == 0
      |=> $stable(regs_q[bdsp_pkg::A_DIAG_A]))
      else $error("write to read-only register took effect");

   a_read_clears: assert property (
      rd_clr && set_a == 0 && set_b == 0 && set_c == 0 &&
      verify_a_set_i == 0 && verify_b_set_i == 0
      |=> regs_q[$past(c_addr)] == 10'h000)
      else $error("read-only register not cleared by read");

   a_mask_blocks: assert property (
      (m_a & regs_q[bdsp_pkg::A_DIAG_A]) == 10'h000
      |=> ($past(m_a) & regs_q[bdsp_pkg::A_DIAG_A]) == 10'h000)
      else $error("masked diagnostic set its bit");

   a_resp_parity: assert property (
      head_fill |=> ^{head_q, resp_q[14:4]} == 1'b1)
      else $error("response parity is not odd");

   a_write_status: assert property (
      head_fill && h_wr |=> resp_q[14:5] == $past(stat_q[9:0]))
      else $error("write response does not carry status");

   a_status_head: assert property (
      s_frame_open |-> resp_q[15:11] == $past(stat_q[14:10]))
      else $error("response does not lead with status");
endmodule
`default_nettype wire

// ---- bdsp_pkg.sv ----
// Shared constants of the bridge driver serial port
// Behaviour
// - Shift input on serial clock rise, strobe low
// - Strobe high: ignore clock, release output
// - Strobe rise after 16 edges commits word
// - Wrong edge count: discard, flag serial error
// - Serial error holds until valid write
// - Top four frame bits select register
// - Write bit set stores ten data bits
// - Write bit clear reads, changes only read-only registers
// - Frame bit zero makes ones count odd
// - Output msb first, fault flag first
// - Write to read-only returns, clears status
// - Read of read-only register clears it
// - Status top five bits lead every response
// - Mask bit fully disables its diagnostic
// - Read clears diagnostic and result registers
// - Timing register: verify time, dead time
// - Monitor A: overcurrent, low-side thresholds
// - Monitor B: qualifiers, disconnect, high-side
// - Monitor C: open-load threshold, verify time
// - Monitor D: enables, selects, phase ratio
// - Sense amp: open-load disable, offset, gain
// - Control: gates, bootstrap, short action, pin
// - Write responses carry low status, parity
package bdsp_pkg;
   localparam int unsigned FRAME_W = 16;
   localparam int unsigned DATA_W  = 10;
   localparam int unsigned STAT_W  = 15;
   localparam int unsigned NREG    = 16;
   localparam logic [4:0]  CNT_HEAD = 5'h04;
   localparam logic [4:0]  CNT_FULL = 5'h10;
   localparam logic [4:0]  CNT_OVER = 5'h11;
   // Register addresses
   localparam logic [3:0] A_TIMING = 4'h0;
   localparam logic [3:0] A_MON_A  = 4'h1;
   localparam logic [3:0] A_MON_B  = 4'h2;
   localparam logic [3:0] A_MON_C  = 4'h3;
   localparam logic [3:0] A_MON_D  = 4'h4;
   localparam logic [3:0] A_SENSE  = 4'h5;
   localparam logic [3:0] A_VCMD_A = 4'h6;
   localparam logic [3:0] A_VCMD_B = 4'h7;
   localparam logic [3:0] A_VRES_A = 4'h8;
   localparam logic [3:0] A_VRES_B = 4'h9;
   localparam logic [3:0] A_MASK_A = 4'ha;
   localparam logic [3:0] A_MASK_B = 4'hb;
   localparam logic [3:0] A_DIAG_A = 4'hc;
   localparam logic [3:0] A_DIAG_B = 4'hd;
   localparam logic [3:0] A_DIAG_C = 4'he;
   localparam logic [3:0] A_CTRL   = 4'hf;
   // Reset values
   localparam logic [9:0] RST_TIMING = 10'h3e0;
   localparam logic [9:0] RST_MON_A  = 10'h258;
   localparam logic [9:0] RST_MON_B  = 10'h018;
   localparam logic [9:0] RST_MON_C  = 10'h210;
   localparam logic [9:0] RST_MON_D  = 10'h060;
   localparam logic [9:0] RST_SENSE  = 10'h0f5;
   localparam logic [9:0] RST_CTRL   = 10'h040;
   localparam logic [9:0] RST_ZERO   = 10'h000;
   // Field lsb positions inside the ten data bits
   localparam int unsigned F_OC_VERIFY_TIME = 6;
   localparam int unsigned F_DEAD_TIME      = 0;
   localparam int unsigned F_OC_THRESHOLD   = 6;
   localparam int unsigned F_LS_DRAIN_THR   = 0;
   localparam int unsigned F_OC_QUAL_MODE   = 9;
   localparam int unsigned F_DRAIN_QUAL     = 8;
   localparam int unsigned F_SUPPLY_DISC    = 6;
   localparam int unsigned F_HS_DRAIN_THR   = 0;
   localparam int unsigned F_OPEN_LOAD_THR  = 6;
   localparam int unsigned F_DRAIN_VERIFY   = 0;
   localparam int unsigned F_ON_OPEN_LOAD   = 9;
   localparam int unsigned F_WATCHDOG_ON    = 8;
   localparam int unsigned F_OL_TEST_CUR    = 7;
   localparam int unsigned F_REG_VOLT_SEL   = 6;
   localparam int unsigned F_PHASE_THR      = 0;
   localparam int unsigned F_OFF_OL_DIS     = 8;
   localparam int unsigned F_SA_OFFSET      = 4;
   localparam int unsigned F_SA_GAIN        = 0;
   localparam int unsigned F_DIAG_PIN_SEL   = 8;
   localparam int unsigned F_BOOT_MGMT_DIS  = 7;
   localparam int unsigned F_SHORT_ACTION   = 6;
   localparam int unsigned F_GATE_B_HIGH    = 3;
   localparam int unsigned F_GATE_B_LOW     = 2;
   localparam int unsigned F_GATE_A_HIGH    = 1;
   localparam int unsigned F_GATE_A_LOW     = 0;
   // Mask bits that gate status monitors and the third fault report
   localparam int unsigned M_A_BOOT  = 7;
   localparam int unsigned M_A_TWARN = 6;
   localparam int unsigned M_B_VBB   = 7;
   localparam int unsigned M_B_LOGIC = 6;

   function automatic logic is_read_only(input logic [3:0] a);
      is_read_only = (a == A_VRES_A) || (a == A_VRES_B) ||
                     (a == A_DIAG_A) || (a == A_DIAG_B) ||
                     (a == A_DIAG_C);
   endfunction

   function automatic logic [9:0] reg_reset(input logic [3:0] a);
      case (a)
         A_TIMING: reg_reset = RST_TIMING;
         A_MON_A:  reg_reset = RST_MON_A;
         A_MON_B:  reg_reset = RST_MON_B;
         A_MON_C:  reg_reset = RST_MON_C;
         A_MON_D:  reg_reset = RST_MON_D;
         A_SENSE:  reg_reset = RST_SENSE;
         A_CTRL:   reg_reset = RST_CTRL;
         default:  reg_reset = RST_ZERO;
      endcase
   endfunction

   function automatic logic odd_parity(input logic [14:0] v);
      odd_parity = ~^v;
   endfunction
endpackage

// ---- bdsp_buf.sv ----
// Two-entry valid/ready buffer for committed frames
`timescale 1ns/1ps
`default_nettype none
module bdsp_buf #(
   parameter int unsigned WIDTH = 16,
   parameter int unsigned DEPTH = 2
) (
   input  wire logic             clk_i,
   input  wire logic             reset_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic      [WIDTH-1:0] out_data_o
);
   localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0]    wr_q;
   logic [PW-1:0]    rd_q;
   logic [PW:0]      cnt_q;
   wire logic        push;
   wire logic        pop;

   function automatic logic [PW-1:0] nxt(input logic [PW-1:0] p);
      nxt = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction

   assign push        = in_valid_i & in_ready_o;
   assign pop         = out_valid_o & out_ready_i;
   assign in_ready_o  = cnt_q != (PW + 1)'(DEPTH);
   assign out_valid_o = cnt_q != '0;
   assign out_data_o  = mem_q[rd_q];

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= nxt(wr_q);
         end
         if (pop) begin
            rd_q <= nxt(rd_q);
         end
         cnt_q <= cnt_q + (PW + 1)'(push) - (PW + 1)'(pop);
      end
   end

   // Data storage needs no reset; valid comes from the count only
   always_ff @(posedge clk_i) begin
      if (push) begin
         mem_q[wr_q] <= in_data_i;
      end
   end
endmodule
`default_nettype wire

// ---- bdsp_host.sv ----
// Host serial master model for the bridge driver port
`timescale 1ns/1ps
`default_nettype none
module bdsp_host (
   output var logic sck_o,
   output var logic sdi_o,
   output var logic strobe_n_o,
   input  wire logic sdo_i
);
   initial begin
      sck_o = 1'b0;
      sdi_o = 1'b0;
      strobe_n_o = 1'b1;
   end
   // Clock idles low and stands still outside frames
   task automatic xfer(input logic [15:0] w, input int n,
                       output logic [15:0] r);
      r = 16'h0000;
      strobe_n_o = 1'b0;
      #80;
      for (int i = 0; i < n; i++) begin
         sdi_o = (i < 16) ? w[15-i] : ~sdi_o;
         #80;
         sck_o = 1'b1;
         r = {r[14:0], sdo_i};
         #80;
         sck_o = 1'b0;
      end
      #80;
      strobe_n_o = 1'b1;
      // Released data line toggles so a stale level is never trusted
      sdi_o = ~sdi_o;
      #80;
   endtask
endmodule
`default_nettype wire

// ---- tb_bridge_driver_serial_port.sv ----
// Self-checking bench for the bridge driver serial port
`timescale 1ns/1ps
`default_nettype none
module tb_bridge_driver_serial_port;
   logic        clk_i, reset_i, sdo, oe, rdy, cv;
   wire logic   sck, sdi, select_strobe_n, sdo_line;
   logic [9:0]  fa, fb, fc, va, vb;
   logic [3:0]  live, caddr;
   wire logic [9:0] cfg [11];
   logic [14:0] st;
   logic [15:0] r;
   int          bad_count = 0;
   int          samples_checked = 0;
   // Released line shows the inverse so a stale bit is never trusted
   assign sdo_line = oe ? sdo : ~sdo;
   bdsp_host host (.sck_o(sck), .sdi_o(sdi), .strobe_n_o(select_strobe_n),
      .sdo_i(sdo_line));
   bdsp_port uut (.clk_i(clk_i), .reset_i(reset_i), .sck_i(sck),
      .sdi_i(sdi), .select_strobe_n_i(select_strobe_n), .sdo_o(sdo), .sdo_oe_o(oe),
      .fault_a_set_i(fa), .fault_b_set_i(fb), .fault_c_set_i(fc),
      .verify_a_set_i(va), .verify_b_set_i(vb), .monitor_live_i(live),
      .commit_ready_i(rdy), .commit_valid_o(cv), .commit_addr_o(caddr),
      .bridge_timing_cfg_o(cfg[0]), .monitor_cfg_a_o(cfg[1]),
      .monitor_cfg_b_o(cfg[2]), .monitor_cfg_c_o(cfg[3]),
      .monitor_cfg_d_o(cfg[4]), .sense_amp_cfg_o(cfg[5]),
      .verify_command_a_o(cfg[6]), .verify_command_b_o(cfg[7]),
      .monitor_disable_a_o(cfg[8]), .monitor_disable_b_o(cfg[9]),
      .bridge_control_o(cfg[10]), .summary_status_o(st));
   localparam logic [9:0] RV [11] = '{10'h3e0, 10'h258, 10'h018, 10'h210,
      10'h060, 10'h0f5, 10'h000, 10'h000, 10'h000, 10'h000, 10'h040};
   function automatic logic [15:0] fr(input logic [3:0] a, input logic w,
                                      input logic [9:0] d);
      fr = {a, w, d, ~^{a, w, d}};
   endfunction
   function automatic logic [15:0] rs(input logic [14:0] v);
      rs = {v, ~^v};
   endfunction
   function automatic logic [3:0] ad(input int i);
      ad = (i < 8) ? 4'(i) : (i < 10) ? 4'(i + 2) : 4'hf;
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic go(input logic [15:0] w, input int n);
      @(posedge clk_i);
      #1;
      host.xfer(w, n, r);
      repeat (4) @(posedge clk_i);
      #1;
      chk(oe, 1'b0);
      if (n == 16)
         chk(^r, 1'b1);
   endtask
   task automatic pulse_a;
      @(posedge clk_i);
      #1;
      fa = 10'h008;
      @(posedge clk_i);
      #1;
      fa = 10'h000;
      // Status follows the diagnostic register one edge later
      @(posedge clk_i);
      #1;
   endtask
   task automatic t_reset;
      for (int i = 0; i < 11; i++)
         chk(cfg[i], RV[i]);
      chk(st, 15'h6000);
      $display("test reset done");
   endtask
   task automatic t_regs;
      logic [9:0]  v;
      logic [14:0] s;
      s = 15'h6000;
      for (int j = 0; j < 2; j++) begin
         for (int i = 0; i < 11; i++) begin
            v = 10'h155 ^ 10'(i);
            go(fr(ad(i), j == 0, (j == 0) ? v : ~v), 16);
            chk(r, (j == 0) ? rs(s) : rs({5'h00, v}));
            chk(cfg[i], v);
            s = 15'h0000;
         end
      end
      $display("test regs done");
   endtask
   task automatic t_serr;
      go(fr(4'h0, 1'b1, 10'h000), 15);
      chk(cfg[0], 10'h155);
      chk(st, 15'h5000);
      go(fr(4'h0, 1'b1, 10'h000), 17);
      chk(cfg[0], 10'h155);
      go(fr(4'h1, 1'b0, 10'h000), 16);
      chk(r, rs({5'h14, 10'h154}));
      chk(st, 15'h5000);
      go(fr(4'h0, 1'b1, 10'h3e0), 16);
      chk(r, rs(15'h5000));
      chk(st, 15'h0000);
      $display("test serial error done");
   endtask
   task automatic t_diag;
      go(fr(4'ha, 1'b1, 10'h000), 16);
      pulse_a;
      chk(st, 15'h4002);
      go(fr(4'hc, 1'b1, 10'h3ff), 16);
      chk(r, rs(15'h4002));
      go(fr(4'hc, 1'b0, 10'h000), 16);
      chk(r, rs({5'h10, 10'h008}));
      go(fr(4'hc, 1'b0, 10'h000), 16);
      chk(r, rs(15'h0000));
      go(fr(4'ha, 1'b1, 10'h008), 16);
      pulse_a;
      go(fr(4'hc, 1'b0, 10'h000), 16);
      chk(r, rs(15'h0000));
      @(posedge clk_i);
      #1;
      va = 10'h010;
      @(posedge clk_i);
      #1;
      va = 10'h000;
      go(fr(4'h8, 1'b0, 10'h000), 16);
      chk(r, rs(15'h0010));
      go(fr(4'h8, 1'b0, 10'h000), 16);
      chk(r, rs(15'h0000));
      $display("test diagnostics done");
   endtask
   task automatic t_stall;
      rdy = 1'b0;
      go(fr(4'hf, 1'b1, 10'h001), 16);
      go(fr(4'hf, 1'b1, 10'h002), 16);
      chk(cfg[10], 10'h15f);
      // Third word finds the buffer full and must be refused
      go(fr(4'hf, 1'b1, 10'h004), 16);
      chk(st, 15'h5000);
      chk(caddr, 4'h8);
      rdy = 1'b1;
      @(posedge clk_i);
      #1;
      chk(cv, 1'b1);
      repeat (5) @(posedge clk_i);
      #1;
      chk(cv, 1'b0);
      chk(cfg[10], 10'h002);
      chk(caddr, 4'hf);
      $display("test stall done");
   endtask
   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   initial begin
      reset_i = 1'b1;
      rdy = 1'b1;
      {fa, fb, fc, va, vb} = '0;
      live = 4'h0;
      repeat (20) @(posedge clk_i);
      #1;
      reset_i = 1'b0;
      repeat (4) @(posedge clk_i);
      #1;
      t_reset;
      t_regs;
      t_serr;
      t_diag;
      t_stall;
      end_sim;
   end
   // About 40 frames of about 2.8 us each; generous margin before giving up
   initial begin
      #400000;
      bad_count++;
      end_sim;
   end
endmodule
`default_nettype wire
